// >>> pkg/gpio_port_pkg.sv
// package: register map, field layout and carriers of the port data block
package gpio_port_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PORT_NUM = 4;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] PORT0_PIN_DATA_OFS = 8'h00;
  localparam logic [7:0] PORT1_PIN_DATA_OFS = 8'h01;
  localparam logic [7:0] PORT2_PIN_DATA_OFS = 8'h02;
  localparam logic [7:0] PORT3_PIN_DATA_OFS = 8'h03;
  localparam logic [7:0] PIN_DRIVE_EN_OFS   = 8'h10;
  localparam logic [7:0] PIN_OPEN_DRAIN_OFS = 8'h14;
  localparam logic [7:0] PORT0_ALT_SEL_OFS  = 8'h18;
  localparam logic [7:0] PORT1_ALT_SEL_OFS  = 8'h19;
  localparam logic [7:0] SUPPLY_USB_CTL_OFS = 8'h1A;

  // ==========================================================================
  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;

  // ==========================================================================
  // implemented bits
  localparam logic [7:0] FULL_PORT_MASK = 8'hFF;
  localparam logic [7:0] NARROW_MASK    = 8'h03;
  localparam logic [7:0] NO_BIT7_MASK   = 8'h7F;
  localparam logic [7:0] NONE_MASK      = 8'h00;
  localparam logic [7:0] ALT0_MASK      = 8'h63;
  localparam logic [7:0] ALT1_MASK      = 8'h78;
  localparam logic [7:0] CTL_MASK       = 8'h07;

  // ==========================================================================
  // pin positions inside port 0 and port 1
  localparam int unsigned P0_CLK_IN   = 0;
  localparam int unsigned P0_CLK_OUT  = 1;
  localparam int unsigned P0_IRQ_LO   = 2;
  localparam int unsigned P0_TIMER_LO = 5;
  localparam int unsigned P1_USB_DP   = 0;
  localparam int unsigned P1_USB_DM   = 1;
  localparam int unsigned P1_REG_OUT  = 2;
  localparam int unsigned P1_SPI_LO   = 3;
  localparam int unsigned TOP_BIT     = 7;

  // ==========================================================================
  // supply and usb control bits
  localparam int unsigned CTL_REG_EN   = 0;
  localparam int unsigned CTL_USB_EN   = 1;
  localparam int unsigned CTL_USB_FORCE = 2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pad_drive_s;

  typedef struct packed {
    logic [1:0] timerIo;
    logic [2:0] extIrq;
    logic       externalClockIn;
    logic [3:0] spi;
    logic [1:0] usb;
  } alt_in_s;

  typedef struct packed {
    logic [1:0] timerOut;
    logic [1:0] timerOe;
    logic       clockOut;
    logic [3:0] spiOut;
    logic [3:0] spiOe;
    logic [1:0] usbOut;
    logic [1:0] usbOe;
  } alt_drive_s;

endpackage

// >>> verilog/gpio_pin_cell.sv
// one pin driver: gpio data, open drain, alternate function takeover
module gpio_pin_cell (
  // gpio side
  input  wire logic dataBit,
  input  wire logic driveEn,
  input  wire logic openDrain,
  input  wire logic present,
  // alternate function side
  input  wire logic altSel,
  input  wire logic altOut,
  input  wire logic altOe,
  // pad side
  output logic      padOut,
  output logic      padOe
);

  // ==========================================================================
  // driver mux
  always_comb begin
    padOut = 1'b0;
    padOe  = 1'b0;
    if (!present) begin
      padOut = 1'b0;
      padOe  = 1'b0;
    end else if (altSel) begin
      padOut = altOut;
      padOe  = altOe;
    end else if (driveEn && openDrain) begin
      padOut = 1'b0;
      padOe  = ~dataBit;
    end else begin
      padOut = dataBit;
      padOe  = driveEn;
    end
  end

endmodule

// >>> verilog/gpio_port_data_registers.sv
// four port data registers (ports 0 and 1 byte-wide, ports 2 and 3 two bits) with pin drivers and shared functions
//
// Chosen here: strobed register access.
module gpio_port_data_registers #(
  parameter bit BIT7_PINS   = 1'b1,
  parameter bit PORT23_PINS = 1'b1
) (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  reset,
  // register port
  input  wire gpio_port_pkg::reg_req_s               regReq,
  output logic [gpio_port_pkg::DATA_W-1:0]           rdata,
  // pads
  input  wire logic [gpio_port_pkg::PORT_NUM-1:0][7:0] padIn,
  output gpio_port_pkg::pad_drive_s [gpio_port_pkg::PORT_NUM-1:0] padDrive,
  // shared functions
  input  wire gpio_port_pkg::alt_drive_s             altDrive,
  output gpio_port_pkg::alt_in_s                     altIn,
  output logic                                       regulatorOutputEn,
  output logic                                       usbModeEn
);

  // ==========================================================================
  // decode helpers
  function automatic logic [7:0] portMask(input logic [1:0] port);
    logic [7:0] m;
    m = gpio_port_pkg::NONE_MASK;
    unique case (port)
      2'h0, 2'h1: m = BIT7_PINS ? gpio_port_pkg::FULL_PORT_MASK
                                : gpio_port_pkg::NO_BIT7_MASK;
      2'h2, 2'h3: m = PORT23_PINS ? gpio_port_pkg::NARROW_MASK
                                  : gpio_port_pkg::NONE_MASK;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] regMask(input logic [1:0] port);
    logic [7:0] m;
    m = gpio_port_pkg::FULL_PORT_MASK;
    if (port[1]) begin
      m = gpio_port_pkg::NARROW_MASK;
    end
    return m;
  endfunction

  function automatic logic isDataAddr(input logic [7:0] a);
    return a[7:2] == gpio_port_pkg::PORT0_PIN_DATA_OFS[7:2];
  endfunction

  function automatic logic isDriveAddr(input logic [7:0] a);
    return a[7:2] == gpio_port_pkg::PIN_DRIVE_EN_OFS[7:2];
  endfunction

  function automatic logic isOdAddr(input logic [7:0] a);
    return a[7:2] == gpio_port_pkg::PIN_OPEN_DRAIN_OFS[7:2];
  endfunction

  function automatic logic isAlt0Addr(input logic [7:0] a);
    return a == gpio_port_pkg::PORT0_ALT_SEL_OFS;
  endfunction

  function automatic logic isAlt1Addr(input logic [7:0] a);
    return a == gpio_port_pkg::PORT1_ALT_SEL_OFS;
  endfunction

  function automatic logic isCtlAddr(input logic [7:0] a);
    return a == gpio_port_pkg::SUPPLY_USB_CTL_OFS;
  endfunction

  // ==========================================================================
  // state
  logic [gpio_port_pkg::PORT_NUM-1:0][7:0] data_q;
  logic [gpio_port_pkg::PORT_NUM-1:0][7:0] driveEn_q;
  logic [gpio_port_pkg::PORT_NUM-1:0][7:0] openDrain_q;
  logic [7:0]                              alt0_q;
  logic [7:0]                              alt1_q;
  logic [7:0]                              ctl_q;
  logic [7:0]                              rdata_q;
  logic [7:0]                              rdata_d;
  gpio_port_pkg::pad_drive_s [gpio_port_pkg::PORT_NUM-1:0] padDrive_q;
  gpio_port_pkg::pad_drive_s [gpio_port_pkg::PORT_NUM-1:0] padDrive_d;
  gpio_port_pkg::alt_in_s                  altIn_q;
  gpio_port_pkg::alt_in_s                  altIn_d;
  logic [1:0]                              wrPort;
  logic [1:0]                              rdPort;

  assign wrPort = regReq.addr[1:0];
  assign rdPort = regReq.addr[1:0];

  // ==========================================================================
  // access strobes
  logic wrData;
  logic wrDrive;
  logic wrOd;
  logic wrAlt0;
  logic wrAlt1;
  logic wrCtl;
  logic rdData;
  logic rdDrive;
  logic rdOd;
  logic rdAlt0;
  logic rdAlt1;
  logic rdCtl;

  assign wrData  = regReq.we && isDataAddr(regReq.addr);
  assign wrDrive = regReq.we && isDriveAddr(regReq.addr);
  assign wrOd    = regReq.we && isOdAddr(regReq.addr);
  assign wrAlt0  = regReq.we && isAlt0Addr(regReq.addr);
  assign wrAlt1  = regReq.we && isAlt1Addr(regReq.addr);
  assign wrCtl   = regReq.we && isCtlAddr(regReq.addr);
  assign rdData  = regReq.re && isDataAddr(regReq.addr);
  assign rdDrive = regReq.re && isDriveAddr(regReq.addr);
  assign rdOd    = regReq.re && isOdAddr(regReq.addr);
  assign rdAlt0  = regReq.re && isAlt0Addr(regReq.addr);
  assign rdAlt1  = regReq.re && isAlt1Addr(regReq.addr);
  assign rdCtl   = regReq.re && isCtlAddr(regReq.addr);

  // ==========================================================================
  // port data registers
  always_ff @(posedge clk) begin
    if (reset) begin
      data_q <= {gpio_port_pkg::PORT_NUM{gpio_port_pkg::DATA_RST}};
    end else if (wrData) begin
      data_q[wrPort] <= regReq.wdata & regMask(wrPort);
    end
  end

  // ==========================================================================
  // drive enable registers
  always_ff @(posedge clk) begin
    if (reset) begin
      driveEn_q <= {gpio_port_pkg::PORT_NUM{gpio_port_pkg::CFG_RST}};
    end else if (wrDrive) begin
      driveEn_q[wrPort] <= regReq.wdata & regMask(wrPort);
    end
  end

  // ==========================================================================
  // open drain registers
  always_ff @(posedge clk) begin
    if (reset) begin
      openDrain_q <= {gpio_port_pkg::PORT_NUM{gpio_port_pkg::CFG_RST}};
    end else if (wrOd) begin
      openDrain_q[wrPort] <= regReq.wdata & regMask(wrPort);
    end
  end

  // ==========================================================================
  // port 0 alternate select
  always_ff @(posedge clk) begin
    if (reset) begin
      alt0_q <= gpio_port_pkg::CFG_RST;
    end else if (wrAlt0) begin
      alt0_q <= regReq.wdata & gpio_port_pkg::ALT0_MASK;
    end
  end

  // ==========================================================================
  // port 1 alternate select
  always_ff @(posedge clk) begin
    if (reset) begin
      alt1_q <= gpio_port_pkg::CFG_RST;
    end else if (wrAlt1) begin
      alt1_q <= regReq.wdata & gpio_port_pkg::ALT1_MASK;
    end
  end

  // ==========================================================================
  // supply and usb control
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_q <= gpio_port_pkg::CFG_RST;
    end else if (wrCtl) begin
      ctl_q <= regReq.wdata & gpio_port_pkg::CTL_MASK;
    end
  end

  // ==========================================================================
  // alternate function routing per pin
  logic [gpio_port_pkg::PORT_NUM-1:0][7:0] altSel;
  logic [gpio_port_pkg::PORT_NUM-1:0][7:0] altOut;
  logic [gpio_port_pkg::PORT_NUM-1:0][7:0] altOe;
  logic [gpio_port_pkg::PORT_NUM-1:0][7:0] present;
  logic                                    regEn;
  logic                                    usbEn;
  logic                                    usbForce;

  assign regEn    = ctl_q[gpio_port_pkg::CTL_REG_EN];
  assign usbEn    = ctl_q[gpio_port_pkg::CTL_USB_EN];
  assign usbForce = ctl_q[gpio_port_pkg::CTL_USB_FORCE];

  // pins that exist and belong to the gpio driver
  always_comb begin
    present = '0;
    for (int p = 0; p < gpio_port_pkg::PORT_NUM; p++) begin
      present[p] = portMask(2'(p));
    end
    // regulator takes the pin, gpio driver off
    if (regEn) begin
      present[1][gpio_port_pkg::P1_REG_OUT] = 1'b0;
    end
  end

  always_comb begin
    altSel  = '0;
    altOut  = '0;
    altOe   = '0;
    // external clock input: gpio settings ignored, driver off
    altSel[0][gpio_port_pkg::P0_CLK_IN] = alt0_q[gpio_port_pkg::P0_CLK_IN];
    // internal clock driven out
    altSel[0][gpio_port_pkg::P0_CLK_OUT] = alt0_q[gpio_port_pkg::P0_CLK_OUT];
    altOut[0][gpio_port_pkg::P0_CLK_OUT] = altDrive.clockOut;
    altOe[0][gpio_port_pkg::P0_CLK_OUT]  = 1'b1;
    // timer capture input / timer output
    for (int i = 0; i < 2; i++) begin
      altSel[0][gpio_port_pkg::P0_TIMER_LO+i] = alt0_q[gpio_port_pkg::P0_TIMER_LO+i];
      altOut[0][gpio_port_pkg::P0_TIMER_LO+i] = altDrive.timerOut[i];
      altOe[0][gpio_port_pkg::P0_TIMER_LO+i]  = altDrive.timerOe[i];
    end
    // spi pins: the spi function owns the driver
    for (int i = 0; i < 4; i++) begin
      altSel[1][gpio_port_pkg::P1_SPI_LO+i] = alt1_q[gpio_port_pkg::P1_SPI_LO+i];
      altOut[1][gpio_port_pkg::P1_SPI_LO+i] = altDrive.spiOut[i];
      altOe[1][gpio_port_pkg::P1_SPI_LO+i]  = altDrive.spiOe[i];
    end
    // usb data lines
    for (int i = 0; i < 2; i++) begin
      altSel[1][gpio_port_pkg::P1_USB_DP+i] = usbEn;
      altOut[1][gpio_port_pkg::P1_USB_DP+i] = usbForce ? data_q[1][gpio_port_pkg::P1_USB_DP+i]
                                                       : altDrive.usbOut[i];
      altOe[1][gpio_port_pkg::P1_USB_DP+i]  = usbForce | altDrive.usbOe[i];
    end
  end

  // ==========================================================================
  // pin cells
  gpio_port_pkg::pad_drive_s [gpio_port_pkg::PORT_NUM-1:0] cellDrive;

  for (genvar p = 0; p < gpio_port_pkg::PORT_NUM; p++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_bit
      gpio_pin_cell u_cell (
        .dataBit   (data_q[p][b]),
        .driveEn   (driveEn_q[p][b]),
        .openDrain (openDrain_q[p][b]),
        .present   (present[p][b]),
        .altSel    (altSel[p][b]),
        .altOut    (altOut[p][b]),
        .altOe     (altOe[p][b]),
        .padOut    (cellDrive[p].out[b]),
        .padOe     (cellDrive[p].oe[b])
      );
    end
  end

  assign padDrive_d = cellDrive;

  always_ff @(posedge clk) begin
    if (reset) begin
      padDrive_q <= '0;
    end else begin
      padDrive_q <= padDrive_d;
    end
  end

  // ==========================================================================
  // pin levels toward the shared functions
  always_comb begin
    altIn_d = '0;
    altIn_d.externalClockIn = padIn[0][gpio_port_pkg::P0_CLK_IN] & alt0_q[gpio_port_pkg::P0_CLK_IN];
    for (int i = 0; i < 3; i++) begin
      altIn_d.extIrq[i] = padIn[0][gpio_port_pkg::P0_IRQ_LO+i];
    end
    for (int i = 0; i < 2; i++) begin
      altIn_d.timerIo[i] = padIn[0][gpio_port_pkg::P0_TIMER_LO+i];
      altIn_d.usb[i]     = padIn[1][gpio_port_pkg::P1_USB_DP+i] & usbEn;
    end
    for (int i = 0; i < 4; i++) begin
      altIn_d.spi[i] = padIn[1][gpio_port_pkg::P1_SPI_LO+i];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      altIn_q <= '0;
    end else begin
      altIn_q <= altIn_d;
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    rdata_d = 8'h00;
    if (rdData) begin
      rdata_d = padIn[rdPort] & portMask(rdPort);
    end else if (rdDrive) begin
      rdata_d = driveEn_q[rdPort];
    end else if (rdOd) begin
      rdata_d = openDrain_q[rdPort];
    end else if (rdAlt0) begin
      rdata_d = alt0_q;
    end else if (rdAlt1) begin
      rdata_d = alt1_q;
    end else if (rdCtl) begin
      rdata_d = ctl_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata             = rdata_q;
  assign padDrive          = padDrive_q;
  assign altIn             = altIn_q;
  assign regulatorOutputEn = regEn;
  assign usbModeEn         = usbEn;

endmodule

// >>> testbench/gpio_port_data_registers_properties.sv
// checker: port-level properties of the port data registers
module gpio_port_data_registers_properties #(
  parameter bit BIT7_PINS   = 1'b1,
  parameter bit PORT23_PINS = 1'b1
) (
  // clock and reset
  input wire logic                                                 clk,
  input wire logic                                                 reset,
  // register port
  input wire gpio_port_pkg::reg_req_s                              regReq,
  input wire logic [gpio_port_pkg::DATA_W-1:0]                     rdata,
  // pads
  input wire logic [gpio_port_pkg::PORT_NUM-1:0][7:0]              padIn,
  input wire gpio_port_pkg::pad_drive_s [gpio_port_pkg::PORT_NUM-1:0] padDrive,
  // shared functions
  input wire gpio_port_pkg::alt_drive_s                            altDrive,
  input wire gpio_port_pkg::alt_in_s                               altIn,
  input wire logic                                                 regulatorOutputEn,
  input wire logic                                                 usbModeEn
);
  // ==========================================================================
  // helpers
  logic [7:0] wideMask;
  logic [7:0] narrowMask;
  assign wideMask   = BIT7_PINS ? 8'hFF : 8'h7F;
  assign narrowMask = PORT23_PINS ? 8'h03 : 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence readOf(logic [7:0] a);
    regReq.re && regReq.addr == a;
  endsequence

  sequence writeOf(logic [7:0] a);
    regReq.we && regReq.addr == a;
  endsequence

  // ==========================================================================
  // properties
  port0_read_a: assert property (readOf(8'h00) |=> rdata == ($past(padIn[0]) & wideMask))
    else $error("port 0 read wrong");
  port1_read_a: assert property (readOf(8'h01) |=> rdata == ($past(padIn[1]) & wideMask))
    else $error("port 1 read wrong");
  port2_read_a: assert property (readOf(8'h02) |=> rdata == ($past(padIn[2]) & narrowMask))
    else $error("port 2 read wrong");
  port3_read_a: assert property (readOf(8'h03) |=> rdata == ($past(padIn[3]) & narrowMask))
    else $error("port 3 read wrong");
  absent_pins_a: assert property (padDrive[2].oe[7:2] == 6'h00 && padDrive[3].oe[7:2] == 6'h00)
    else $error("absent pin driven");
  regulator_pin_a: assert property (regulatorOutputEn && $past(regulatorOutputEn) |-> !padDrive[1].oe[2])
    else $error("regulator pin driven");
  irq_forward_a: assert property (1'b1 |=> altIn.extIrq == $past(padIn[0][4:2]))
    else $error("interrupt pins not forwarded");
  reset_clear_a: assert property ($fell(reset) |-> padDrive == '0 && !usbModeEn && !regulatorOutputEn)
    else $error("not cleared by reset");
  data_drive_a: assert property (writeOf(8'h02) ##1 !regReq.we |=>
    (padDrive[2].out[0] == $past(regReq.wdata[0], 2)) ||
    (!padDrive[2].out[0] && padDrive[2].oe[0] == !$past(regReq.wdata[0], 2)))
    else $error("port 2 pin drive wrong");
endmodule

bind gpio_port_data_registers gpio_port_data_registers_properties #(
  .BIT7_PINS  (BIT7_PINS),
  .PORT23_PINS(PORT23_PINS)
) u_props (
  .clk(clk), .reset(reset), .regReq(regReq), .rdata(rdata), .padIn(padIn), .padDrive(padDrive),
  .altDrive(altDrive), .altIn(altIn), .regulatorOutputEn(regulatorOutputEn), .usbModeEn(usbModeEn)
);

// >>> testbench/gpio_board_model.sv
// partner: board lines seen by the pads
module gpio_board_model (
  // pad drive from the device
  input wire gpio_port_pkg::pad_drive_s [3:0] padDrive,
  // level of each undriven line, changed by the bench
  input wire logic [3:0][7:0]                floatLevel,
  // levels seen by the device
  output logic [3:0][7:0]                    padIn
);
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      padIn[p] = (padDrive[p].oe & padDrive[p].out) | (~padDrive[p].oe & floatLevel[p]);
    end
  end
endmodule

// >>> testbench/test_gpio_port_data_registers.sv
// testbench: port data registers against a register-level model
module test_gpio_port_data_registers;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // signals and model state
  logic                            clk;
  logic                            reset;
  gpio_port_pkg::reg_req_s         regReq;
  logic [7:0]                      rdata;
  logic [3:0][7:0]                 padIn;
  gpio_port_pkg::pad_drive_s [3:0] padDrive;
  gpio_port_pkg::alt_drive_s       altDrive;
  gpio_port_pkg::alt_in_s          altIn;
  logic                            regulatorOutputEn;
  logic                            usbModeEn;
  logic [3:0][7:0]                 floatLevel;
  logic [31:0]                     r;
  int                              n_fail;
  int                              compares;
  int                              dataM[4];
  int                              enM[4];
  int                              odM[4];
  int                              ctlM;
  int                              alt0M;
  int                              alt1M;
  int                              o;
  int                              e;

  gpio_port_data_registers u_dut (
    .clk(clk), .reset(reset), .regReq(regReq), .rdata(rdata), .padIn(padIn), .padDrive(padDrive),
    .altDrive(altDrive), .altIn(altIn), .regulatorOutputEn(regulatorOutputEn), .usbModeEn(usbModeEn)
  );

  gpio_board_model u_board (.padDrive(padDrive), .floatLevel(floatLevel), .padIn(padIn));

  // ==========================================================================
  // model
  function automatic int portMask(input int p);
    return (p < 2) ? 8'hFF : 8'h03;
  endfunction

  function automatic void expDrive(input int p, output int oo, output int ee);
    int d;
    oo = 0;
    ee = 0;
    for (int b = 0; b < 8; b++) begin
      d = (dataM[p] >> b) & 1;
      if (((portMask(p) >> b) & 1) == 0 || (p == 1 && b == 2 && ctlM[0])) begin
        continue;
      end else if (p == 0 && b == 0 && alt0M[0]) begin
        continue;
      end else if (p == 0 && b == 1 && alt0M[1]) begin
        oo |= int'(altDrive.clockOut) << 1;
        ee |= 1 << 1;
      end else if (p == 0 && (b == 5 || b == 6) && alt0M[b]) begin
        oo |= int'(altDrive.timerOut[b-5]) << b;
        ee |= int'(altDrive.timerOe[b-5]) << b;
      end else if (p == 1 && b >= 3 && b <= 6 && alt1M[b]) begin
        oo |= int'(altDrive.spiOut[b-3]) << b;
        ee |= int'(altDrive.spiOe[b-3]) << b;
      end else if (p == 1 && b < 2 && ctlM[1]) begin
        oo |= (ctlM[2] ? d : int'(altDrive.usbOut[b])) << b;
        ee |= (ctlM[2] ? 1 : int'(altDrive.usbOe[b])) << b;
      end else if (enM[p][b] && odM[p][b]) begin
        ee |= (1 - d) << b;
      end else begin
        oo |= d << b;
        ee |= enM[p][b] << b;
      end
    end
  endfunction

  function automatic logic [7:0] pinLevel(input int p);
    int oo;
    int ee;
    expDrive(p, oo, ee);
    return 8'(((ee & oo) | (~ee & int'(floatLevel[p]))) & portMask(p));
  endfunction

  // ==========================================================================
  // tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    if (a < 8'h04) dataM[a] = d & portMask(a);
    else if (a[7:2] == 6'h04) enM[a[1:0]] = d & portMask(a[1:0]);
    else if (a[7:2] == 6'h05) odM[a[1:0]] = d & portMask(a[1:0]);
    else if (a == 8'h1A) ctlM = d & 8'h07;
    else if (a == 8'h18) alt0M = d & 8'h63;
    else if (a == 8'h19) alt1M = d & 8'h78;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regReq <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    regReq <= '0;
    @(negedge clk);
    check(rdata, exp);
    @(posedge clk);
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #20000;
    n_fail++;
    test_done();
  end

  initial begin
    void'($urandom(32'hFB43EF24));
    reset = 1'b1;
    regReq = '0;
    altDrive = '0;
    floatLevel = '0;
    n_fail = 0;
    compares = 0;
    ctlM = 0;
    alt0M = 0;
    alt1M = 0;
    for (int p = 0; p < 4; p++) begin
      dataM[p] = 0;
      enM[p] = 0;
      odM[p] = 0;
    end
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int it = 0; it < 40; it++) begin
      r = $urandom;
      floatLevel <= $urandom;
      altDrive <= r[16:0];
      wr(8'h10 + 8'($urandom_range(3)), 8'($urandom));
      wr(8'h14 + 8'($urandom_range(3)), 8'($urandom));
      wr(8'h1A, 8'($urandom));
      wr(8'h18, 8'($urandom));
      wr(8'h19, 8'($urandom));
      wr(8'h20, 8'($urandom));
      wr(8'h00 + 8'(it % 4), 8'($urandom));
      regReq <= '0;
      repeat (2) @(posedge clk);
      for (int a = 0; a < 4; a++) rd(8'(a), pinLevel(a));
      rd(8'h20, 8'h00);
      rd(8'h18, 8'(alt0M));
      rd(8'h19, 8'(alt1M));
      rd(8'h1A, 8'(ctlM));
      for (int p = 0; p < 4; p++) begin
        expDrive(p, o, e);
        check(padDrive[p].oe, 8'(e));
        check(padDrive[p].out & 8'(e), 8'(o & e));
      end
      check(8'(altIn.extIrq), 8'(pinLevel(0) >> 2) & 8'h07);
      check({7'h00, altIn.externalClockIn}, 8'(pinLevel(0) & alt0M & 1));
      check({2'h0, altIn.spi, altIn.timerIo}, 8'((((pinLevel(1) >> 3) & 8'h0F) << 2) | ((pinLevel(0) >> 5) & 3)));
      check({6'h00, altIn.usb}, 8'(pinLevel(1) & (ctlM[1] ? 3 : 0)));
      check({6'h00, usbModeEn, regulatorOutputEn}, 8'(ctlM & 3));
    end
    test_done();
  end
endmodule
